// File: hw/boundary_scan_test_port.sv
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        resetn_in,
    // Test port pins
    input  wire tap_pkg::tap_pins_t          tap_in,
    output logic                             tdo_out,
    output logic                             tdo_oe_out,
    // Core pin boundary
    input  wire logic [tap_pkg::N_IN-1:0]    pin_in,
    input  wire tap_pkg::pin_drive_t         core_drive_in,
    output tap_pkg::pin_drive_t              pin_drive_out,
    // Sampled boundary snapshots
    output logic                             snap_valid_out,
    output tap_pkg::bsr_word_t               snap_data_out,
    input  wire logic                        snap_ready_in,
    output logic                             snap_lost_out,
    // Status
    output logic [tap_pkg::IR_W-1:0]         ir_out,
    output logic                             in_reset_out
);
    import tap_pkg::*;

    // Pins come from the tester, outside this clock domain
    tap_pins_t  pins_s1_ff;
    tap_pins_t  pins_s2_ff;
    logic       tck_prev_ff;
    logic       tck_rise;
    logic       tck_fall;
    logic       tms;
    logic       tdi;
    logic       trst_act;

    tap_state_t state_ff;
    tap_state_t nxt_state;

    logic [IR_W-1:0] ir_sh_ff;
    logic [IR_W-1:0] ir_ff;
    logic            byp_ff;
    bsr_word_t       bsr_ff;
    bsr_word_t       upd_ff;
    bsr_word_t       capture_word;

    logic            sel_bypass;
    logic            sel_extest;
    logic            sel_sample;
    logic            shifting;
    logic            serial_out;

    logic            tdo_ff;
    logic            tdo_oe_ff;
    logic            lost_ff;

    logic            snap_push;
    logic            snap_room;

    // Synchroniser resets to the idle pin levels: the pulled-up pins
    // read one and the test clock stands low
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pins_s1_ff <= PINS_PULLED;
            pins_s2_ff <= PINS_PULLED;
        end else begin
            pins_s1_ff <= tap_in;
            pins_s2_ff <= pins_s1_ff;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            // Same level as the synchronised idle clock, so no false edge
            tck_prev_ff <= 1'b0;
        end else begin
            tck_prev_ff <= pins_s2_ff.tck;
        end
    end

    // Edges of the test clock, found by oversampling: the functional
    // clock never gates or follows it, so both run independently;
    // a test clock phase shorter than one clock may be missed
    assign tck_rise = pins_s2_ff.tck & ~tck_prev_ff;
    assign tck_fall = ~pins_s2_ff.tck & tck_prev_ff;
    assign tms      = pins_s2_ff.tms;
    assign tdi      = pins_s2_ff.tdi;
    // Test reset takes the synchroniser path as well: it lands two or
    // three clocks after the pin falls and needs no test clock edge
    assign trst_act = ~pins_s2_ff.trst_n;

    // Controller transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_TLR: begin
                nxt_state = tms ? ST_TLR : ST_RTI;
            end
            ST_RTI: begin
                nxt_state = tms ? ST_SELDR : ST_RTI;
            end
            ST_SELDR: begin
                nxt_state = tms ? ST_SELIR : ST_CAPDR;
            end
            ST_CAPDR: begin
                nxt_state = tms ? ST_EX1DR : ST_SHDR;
            end
            ST_SHDR: begin
                nxt_state = tms ? ST_EX1DR : ST_SHDR;
            end
            ST_EX1DR: begin
                nxt_state = tms ? ST_UPDR : ST_PSDR;
            end
            ST_PSDR: begin
                nxt_state = tms ? ST_EX2DR : ST_PSDR;
            end
            ST_EX2DR: begin
                nxt_state = tms ? ST_UPDR : ST_SHDR;
            end
            ST_UPDR: begin
                nxt_state = tms ? ST_SELDR : ST_RTI;
            end
            ST_SELIR: begin
                nxt_state = tms ? ST_TLR : ST_CAPIR;
            end
            ST_CAPIR: begin
                nxt_state = tms ? ST_EX1IR : ST_SHIR;
            end
            ST_SHIR: begin
                nxt_state = tms ? ST_EX1IR : ST_SHIR;
            end
            ST_EX1IR: begin
                nxt_state = tms ? ST_UPIR : ST_PSIR;
            end
            ST_PSIR: begin
                nxt_state = tms ? ST_EX2IR : ST_PSIR;
            end
            ST_EX2IR: begin
                nxt_state = tms ? ST_UPIR : ST_SHIR;
            end
            ST_UPIR: begin
                nxt_state = tms ? ST_SELDR : ST_RTI;
            end
            default: begin
                nxt_state = ST_TLR;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            state_ff <= ST_TLR;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // Instruction register
    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            ir_sh_ff <= IR_RESET;
        end else if (tck_rise) begin
            if (state_ff == ST_CAPIR) begin
                // Fixed pattern lets the tester confirm the chain length
                ir_sh_ff <= IR_CAPTURE;
            end else if (state_ff == ST_SHIR) begin
                ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            ir_ff <= IR_RESET;
        end else if (tck_rise) begin
            if (state_ff == ST_TLR) begin
                ir_ff <= IR_RESET;
            end else if (state_ff == ST_UPIR) begin
                ir_ff <= ir_sh_ff;
            end
        end
    end

    // Decode: both mixed codes mean sample/preload, so no code is
    // left without a data register
    always_comb begin
        sel_extest = 1'b0;
        sel_bypass = 1'b0;
        sel_sample = 1'b0;
        case (ir_ff)
            IR_EXTEST: begin
                sel_extest = 1'b1;
            end
            IR_BYPASS: begin
                sel_bypass = 1'b1;
            end
            default: begin
                sel_sample = 1'b1;
            end
        endcase
    end

    // Capture: pin inputs, then core output data, then core enables
    always_comb begin
        capture_word = '0;
        capture_word[POS_IN +: N_IN]    = pin_in;
        capture_word[POS_DATA +: N_OUT] = core_drive_in.data;
        capture_word[POS_OE +: N_OUT]   = core_drive_in.oe;
    end

    // Bypass stage, one flip-flop; it captures zero so a tester can
    // count the stages of a chain
    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            byp_ff <= 1'b0;
        end else if (tck_rise && sel_bypass) begin
            if (state_ff == ST_CAPDR) begin
                byp_ff <= 1'b0;
            end else if (state_ff == ST_SHDR) begin
                byp_ff <= tdi;
            end
        end
    end

    // Boundary chain shifts toward cell 0, which leaves first
    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            bsr_ff <= '0;
        end else if (tck_rise && !sel_bypass) begin
            if (state_ff == ST_CAPDR) begin
                bsr_ff <= capture_word;
            end else if (state_ff == ST_SHDR) begin
                bsr_ff <= {tdi, bsr_ff[BSR_LEN-1:1]};
            end
        end
    end

    // Update latch only changes on Update-DR, so shifting never
    // reaches the pins while the core runs
    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            upd_ff <= '0;
        end else if (tck_rise && !sel_bypass && state_ff == ST_UPDR) begin
            upd_ff <= bsr_ff;
        end
    end

    // Pins follow the core except under EXTEST; enables are active high
    always_comb begin
        pin_drive_out = core_drive_in;
        if (sel_extest) begin
            pin_drive_out.data = upd_ff[POS_DATA +: N_OUT];
            pin_drive_out.oe   = upd_ff[POS_OE +: N_OUT];
        end
    end

    // Serial path: Shift-IR reads the instruction stage, a data scan
    // reads whichever register the instruction selected
    assign shifting = (state_ff == ST_SHDR) || (state_ff == ST_SHIR);

    always_comb begin
        serial_out = bsr_ff[0];
        if (state_ff == ST_SHIR) begin
            serial_out = ir_sh_ff[0];
        end else if (sel_bypass) begin
            serial_out = byp_ff;
        end
    end

    // Data-out and its enable move only on falling edges or a reset; outside a
    // shift the pad reads the idle level, never a stale cell
    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_ff <= shifting;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            tdo_ff <= TDO_IDLE;
        end else if (tck_fall) begin
            if (shifting) begin
                tdo_ff <= serial_out;
            end else begin
                tdo_ff <= TDO_IDLE;
            end
        end
    end

    assign tdo_out    = tdo_ff;
    assign tdo_oe_out = tdo_oe_ff;

    // A sample snapshot is offered at each sample/preload Capture-DR; a full buffer
    // cannot stall the tester, so the snapshot is dropped and flagged
    assign snap_push = tck_rise && sel_sample && (state_ff == ST_CAPDR);

    always_ff @(posedge clk_in) begin
        if (!resetn_in || trst_act) begin
            lost_ff <= 1'b0;
        end else if (snap_push && !snap_room) begin
            lost_ff <= 1'b1;
        end
    end

    // Only the functional reset empties the buffer: snapshots already
    // queued stay readable across a test reset
    scan_fifo #(
        .W     (BSR_LEN),
        .DEPTH (FIFO_DEPTH)
    ) u_snap_fifo (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (snap_push),
        .in_data_in    (capture_word),
        .in_ready_out  (snap_room),
        .out_valid_out (snap_valid_out),
        .out_data_out  (snap_data_out),
        .out_ready_in  (snap_ready_in)
    );

    assign snap_lost_out = lost_ff;
    assign ir_out        = ir_ff;
    assign in_reset_out  = (state_ff == ST_TLR);
endmodule // boundary_scan_test_port
`default_nettype wire

// File: hw/tap_pkg.sv
package tap_pkg;
    // Boundary chain layout: inputs, then output data, then output enables
    localparam int N_IN      = 4;
    localparam int N_OUT     = 2;
    localparam int BSR_LEN   = N_IN + 2 * N_OUT;
    localparam int POS_IN    = 0;
    localparam int POS_DATA  = N_IN;
    localparam int POS_OE    = N_IN + N_OUT;
    localparam int IR_W      = 2;
    localparam int FIFO_DEPTH = 4;

    localparam logic [IR_W-1:0] IR_EXTEST  = 2'h0;
    localparam logic [IR_W-1:0] IR_BYPASS  = 2'h3;
    localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
    localparam logic [IR_W-1:0] IR_RESET   = IR_BYPASS;
    localparam logic            TDO_IDLE   = 1'h1;

    typedef logic [BSR_LEN-1:0] bsr_word_t;

    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_RTI   = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PSDR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PSIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_pins_t;

    // Idle levels: test clock low, the pulled-up pins high
    localparam tap_pins_t PINS_PULLED = 4'h7;

    typedef struct packed {
        logic [N_OUT-1:0] data;
        logic [N_OUT-1:0] oe;
    } pin_drive_t;
endpackage

// File: hw/scan_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module scan_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    // Fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // Drain side
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [CW-1:0] cnt_ff;
    logic          push;
    logic          pop;

    assign in_ready_out  = (cnt_ff != CW'(DEPTH));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out  = mem_ff[rd_ff];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // scan_fifo
`default_nettype wire

// File: sim/boundary_scan_test_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port_props (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    // Test port pins
    input  wire tap_pkg::tap_pins_t   tap_in,
    input  wire logic                 tdo_out,
    input  wire logic                 tdo_oe_out,
    // Core pin boundary
    input  wire logic [tap_pkg::N_IN-1:0] pin_in,
    input  wire tap_pkg::pin_drive_t  core_drive_in,
    input  wire tap_pkg::pin_drive_t  pin_drive_out,
    // Snapshots and status
    input  wire logic                 snap_valid_out,
    input  wire tap_pkg::bsr_word_t   snap_data_out,
    input  wire logic                 snap_ready_in,
    input  wire logic                 snap_lost_out,
    input  wire logic [tap_pkg::IR_W-1:0] ir_out,
    input  wire logic                 in_reset_out
);
    import tap_pkg::*;
    logic       tck_q_ff;
    logic [3:0] fall_cnt_ff;
    logic [3:0] rise_cnt_ff;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    always_ff @(posedge clk_in) begin
        tck_q_ff <= resetn_in & tap_in.tck;
    end

    // Ages of the last raw test-clock edges; the design answers a few cycles later through its synchroniser
    always_ff @(posedge clk_in) begin
        if (!resetn_in || (tck_q_ff && !tap_in.tck)) fall_cnt_ff <= resetn_in ? 4'h0 : 4'hF;
        else if (fall_cnt_ff != 4'hF) fall_cnt_ff <= fall_cnt_ff + 4'h1;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in || (!tck_q_ff && tap_in.tck)) rise_cnt_ff <= resetn_in ? 4'h0 : 4'hF;
        else if (rise_cnt_ff != 4'hF) rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end

    sequence trst_held;
        !tap_in.trst_n [*5];
    endsequence

    sequence snap_stall;
        snap_valid_out && !snap_ready_in;
    endsequence

    a_reset_values: assert property (disable iff (1'b0) !resetn_in |=> ir_out == IR_RESET && in_reset_out
        && !tdo_oe_out && tdo_out == TDO_IDLE && !snap_valid_out && !snap_lost_out)
        else $error("state after functional reset is wrong");
    a_trst_forces: assert property (trst_held |-> in_reset_out && ir_out == IR_RESET && !tdo_oe_out
        && !snap_lost_out)
        else $error("test reset did not reset the scan logic");
    a_tdo_idle_level: assert property (!tdo_oe_out |-> tdo_out == TDO_IDLE)
        else $error("data out not at idle level while disabled");
    a_tdo_on_fall: assert property (($changed(tdo_out) || $changed(tdo_oe_out)) && !in_reset_out
        |-> fall_cnt_ff <= 4'h5)
        else $error("data out changed away from a test clock fall");
    a_ir_on_rise: assert property ($changed(ir_out) && !in_reset_out |-> rise_cnt_ff <= 4'h5)
        else $error("instruction changed away from a test clock rise");
    a_pin_pass: assert property (ir_out != IR_EXTEST |-> pin_drive_out == core_drive_in)
        else $error("pins not driven by the core outside external test");
    a_extest_holds: assert property (ir_out == IR_EXTEST && $stable(ir_out) && rise_cnt_ff > 4'h8
        |-> $stable(pin_drive_out))
        else $error("pin drive moved under external test without a scan");
    a_snap_holds: assert property (snap_stall |=> snap_valid_out && $stable(snap_data_out))
        else $error("snapshot head changed while stalled");
    a_lost_sticky: assert property (snap_lost_out && tap_in.trst_n |=> snap_lost_out)
        else $error("lost flag cleared without reset");
    a_oe_outside_reset: assert property (tdo_oe_out |-> !in_reset_out)
        else $error("data out enabled in test logic reset");
endmodule // boundary_scan_test_port_props

bind boundary_scan_test_port boundary_scan_test_port_props u_props (
    .clk_in(clk_in), .resetn_in(resetn_in), .tap_in(tap_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .pin_in(pin_in), .core_drive_in(core_drive_in), .pin_drive_out(pin_drive_out),
    .snap_valid_out(snap_valid_out), .snap_data_out(snap_data_out), .snap_ready_in(snap_ready_in),
    .snap_lost_out(snap_lost_out), .ir_out(ir_out), .in_reset_out(in_reset_out));
`default_nettype wire

// File: sim/scan_controller_model.sv
`timescale 1ns/100ps
`default_nettype none
module scan_controller_model (
    // Test port drive
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    output logic      trst_n_out,
    // Test port return
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in
);
    // Undriven pins are pulled high on the pad, so they idle at one and the clock stands low
    initial begin
        tck_out    = 1'b0;
        tms_out    = 1'b1;
        tdi_out    = 1'b1;
        trst_n_out = 1'b1;
    end

    // One 200 ns test clock; data out is read well after the previous fall
    task automatic pulse(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_out = tms;
        tdi_out = tdi;
        #100 tck_out = 1'b1;
        #50 tdo = tdo_in;
        oe = tdo_oe_in;
        #50 tck_out = 1'b0;
    endtask

    // Full scan from run-test-idle back to run-test-idle; the 7 ns skew keeps it off the system clock
    task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout,
                        output logic ok);
        logic t;
        logic o;
        dout = 16'h0;
        ok = 1'b1;
        #7;
        pulse(1'b1, 1'b1, t, o);
        if (ir) pulse(1'b1, 1'b1, t, o);
        pulse(1'b0, 1'b1, t, o);
        pulse(1'b0, 1'b1, t, o);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], dout[i], o);
            ok &= (o === 1'b1);
        end
        pulse(1'b1, 1'b1, t, o);
        ok &= (o === 1'b0);
        pulse(1'b0, 1'b1, t, o);
    endtask

    task automatic to_reset();
        logic t;
        logic o;
        #7;
        for (int i = 0; i < 5; i++) pulse(1'b1, 1'b1, t, o);
    endtask

    task automatic trst();
        #7 trst_n_out = 1'b0;
        #300 trst_n_out = 1'b1;
        #150;
    endtask
endmodule // scan_controller_model
`default_nettype wire

// File: sim/boundary_scan_test_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_test_port_tb;
    import tap_pkg::*;
    logic       clk_in;
    logic       resetn_in;
    tap_pins_t  tap_in;
    logic       tck, tms, tdi, trst_n, tdo_out, tdo_oe_out;
    logic [3:0] pin_in;
    pin_drive_t core_drive_in, pin_drive_out;
    logic       snap_valid_out, snap_ready_in, snap_lost_out, in_reset_out;
    bsr_word_t  snap_data_out;
    logic [1:0] ir_out;
    int         miscompares, n_tests;

    boundary_scan_test_port uut (.clk_in(clk_in), .resetn_in(resetn_in), .tap_in(tap_in), .tdo_out(tdo_out),
        .tdo_oe_out(tdo_oe_out), .pin_in(pin_in), .core_drive_in(core_drive_in), .pin_drive_out(pin_drive_out),
        .snap_valid_out(snap_valid_out), .snap_data_out(snap_data_out), .snap_ready_in(snap_ready_in),
        .snap_lost_out(snap_lost_out), .ir_out(ir_out), .in_reset_out(in_reset_out));
    scan_controller_model ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
        .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
    assign tap_in = tap_pins_t'({tck, tms, tdi, trst_n});

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic set_ir(input logic [1:0] code);
        logic [15:0] got;
        logic        ok;
        ctl.scan(1'b1, IR_W, {14'h0, code}, got, ok);
        #100;
        check(got, 16'h1);
        check(ok, 1'b1);
        check(ir_out, code);
        check(in_reset_out, 1'b0);
    endtask

    task automatic dr(input logic [15:0] din, input int n, output logic [15:0] got);
        logic ok;
        ctl.scan(1'b0, n, din, got, ok);
        #100;
        check(ok, 1'b1);
    endtask

    task automatic t_reset();
        check(ir_out, IR_RESET);
        check(in_reset_out, 1'b1);
        check({tdo_oe_out, tdo_out}, 2'h1);
        check(pin_drive_out, core_drive_in);
        check({snap_valid_out, snap_lost_out}, 2'h0);
    endtask

    task automatic t_bypass();
        logic [15:0] got;
        logic        t;
        logic        o;
        ctl.pulse(1'b0, 1'b1, t, o);
        set_ir(IR_BYPASS);
        dr(16'h00A5, 8, got);
        check(got, 16'h004A);
    endtask

    // Five captures with the consumer stalled: four are kept, the fifth is dropped
    task automatic t_sample_fifo();
        logic [15:0] got;
        bsr_word_t   w [5];
        pin_drive_t  c;
        for (int k = 0; k < 5; k++) begin
            set_ir(k[0] ? 2'h2 : 2'h1);
            @(posedge clk_in);
            pin_in <= 4'(k * 5 + 1);
            c = pin_drive_t'(4'(9 - k));
            core_drive_in <= c;
            w[k] = {c.oe, c.data, 4'(k * 5 + 1)};
            dr(16'h0, BSR_LEN, got);
            check(got, w[k]);
            check(pin_drive_out, core_drive_in);
        end
        check({snap_valid_out, snap_lost_out}, 2'h3);
        for (int j = 0; j < FIFO_DEPTH; j++) begin
            check(snap_valid_out, 1'b1);
            check(snap_data_out, w[j]);
            @(posedge clk_in) snap_ready_in <= 1'b1;
            @(posedge clk_in) snap_ready_in <= 1'b0;
            #1;
        end
        check(snap_valid_out, 1'b0);
    endtask

    task automatic t_extest();
        logic [15:0] got;
        set_ir(IR_EXTEST);
        dr(16'h0090, BSR_LEN, got);
        check(pin_drive_out, 4'h6);
        @(posedge clk_in) core_drive_in <= ~core_drive_in;
        #100;
        check(pin_drive_out, 4'h6);
    endtask

    task automatic t_tap_resets();
        logic t;
        logic o;
        ctl.to_reset();
        #100;
        check({in_reset_out, ir_out}, {1'b1, IR_RESET});
        ctl.pulse(1'b0, 1'b1, t, o);
        #100;
        check(in_reset_out, 1'b0);
        set_ir(IR_EXTEST);
        check(snap_lost_out, 1'b1);
        ctl.trst();
        check({in_reset_out, ir_out}, {1'b1, IR_RESET});
        check({snap_lost_out, tdo_oe_out}, 2'h0);
        check(pin_drive_out, core_drive_in);
    endtask

    initial begin
        miscompares = 0;
        n_tests = 0;
        resetn_in = 1'b0;
        pin_in = 4'h0;
        core_drive_in = pin_drive_t'(4'h0);
        snap_ready_in = 1'b0;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        t_reset();
        t_bypass();
        t_sample_fifo();
        t_extest();
        t_tap_resets();
        test_done();
    end

    initial begin
        #400000;
        miscompares++;
        test_done();
    end
endmodule // boundary_scan_test_port_tb
`default_nettype wire
